// ### pbocr_pkg.sv
package pbocr_pkg;

  localparam logic [7:0] ADDR_LOCK      = 8'h00;
  localparam logic [7:0] LOCK_VALUE     = 8'hA6;
  localparam logic [7:0] ADDR_P6_GAIN   = 8'h1B;
  localparam logic [7:0] ADDR_P6_OFFSET = 8'h1C;
  localparam logic [7:0] ADDR_P7_GAIN   = 8'h1D;
  localparam logic [7:0] ADDR_P7_OFFSET = 8'h1E;
  localparam logic [7:0] ADDR_P8_GAIN   = 8'h1F;
  localparam logic [7:0] ADDR_P8_OFFSET = 8'h20;
  localparam logic [7:0] ADDR_OC_LO     = 8'h21;
  localparam logic [7:0] ADDR_OC_HI     = 8'h22;

  localparam int         BAL_PHASES     = 3;
  localparam logic [4:0] GAIN_RESET     = 5'h10;
  localparam logic [4:0] OFFSET_RESET   = 5'h00;
  localparam logic [7:0] OC_RESET       = 8'h00;
  localparam logic [7:0] LOCK_RESET     = 8'h00;
  localparam int         OFS_SIGN_BIT   = 4;
  localparam int         OFS_MAG_MSB    = 3;
  localparam int         OC_FIELD_W     = 2;

  typedef struct packed {
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pbocr_wr_s;

  typedef struct packed {
    logic       negative;
    logic [3:0] magnitude;
  } pbocr_offset_s;

  typedef struct packed {
    logic [4:0]    gain;
    pbocr_offset_s offset;
  } pbocr_phase_s;

endpackage : pbocr_pkg

// ### pbocr_phase_reg.sv
`timescale 1ns/10ps
module pbocr_phase_reg #(
  parameter logic [7:0] GAIN_ADDR   = 8'h1B,
  parameter logic [7:0] OFFSET_ADDR = 8'h1C
) (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_ce,
  input  wire pbocr_pkg::pbocr_wr_s    i_wr,
  input  wire logic                    i_unlocked,
  output pbocr_pkg::pbocr_phase_s      o_phase
);

  pbocr_pkg::pbocr_phase_s st_r;
  pbocr_pkg::pbocr_phase_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (i_wr.wr_en && i_unlocked) begin
      if (i_wr.addr == GAIN_ADDR) begin
        st_nxt.gain = i_wr.wdata[4:0];
      end
      if (i_wr.addr == OFFSET_ADDR) begin
        st_nxt.offset.negative  = i_wr.wdata[pbocr_pkg::OFS_SIGN_BIT];
        st_nxt.offset.magnitude = i_wr.wdata[pbocr_pkg::OFS_MAG_MSB:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r.gain   <= pbocr_pkg::GAIN_RESET;
      st_r.offset <= pbocr_pkg::OFFSET_RESET;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_phase = st_r;

  a_locked_gain_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_wr.wr_en && !i_unlocked) |=> $stable(st_r))
    else $error("phase register changed while locked");

  a_gain_write_lands: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_wr.wr_en && i_unlocked && i_wr.addr == GAIN_ADDR)
      |=> (st_r.gain == $past(i_wr.wdata[4:0])))
    else $error("gain write not stored");

  a_offset_sign_lands: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_wr.wr_en && i_unlocked && i_wr.addr == OFFSET_ADDR)
      |=> (st_r.offset.negative == $past(i_wr.wdata[4])))
    else $error("offset polarity not stored");

  a_offset_mag_lands: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_wr.wr_en && i_unlocked && i_wr.addr == OFFSET_ADDR)
      |=> (st_r.offset.magnitude == $past(i_wr.wdata[3:0])))
    else $error("offset magnitude not stored");

endmodule : pbocr_phase_reg

// ### pbocr_regs.sv
`timescale 1ns/10ps
// Contract
// - balance gain is five bits, code n means (n+1)/16, resets to 10000
// - offset bit 4 picks polarity, 0 positive, 1 negative, resets 0
// - offset bits 3:0 give 15 mV steps per reference_input_voltage, reset 0000
// - gated fields are writable only while register 0x00 is not 0xA6
// - two-bit overcurrent gain: 00 1x, 01 0.9x, 10 0.8x, 11 0.7x, reset 00
// - phases1to4_overcurrent_gain holds phases one to four, phases5to8_overcurrent_gain phases five to eight, low phase low bits
// - balance pairs: phase6_balance_gain/phase6_balance_offset phase six, phase7_balance_gain/phase7_balance_offset seven, phase8_balance_gain/phase8_balance_offset eight
module pbocr_regs (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_wr_en,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata,
  output logic             o_locked,
  output logic      [29:0] o_bal_cfg,
  output logic      [15:0] o_oc_gain
);

  // lock register, the two overcurrent words and registered read data; balance phases live in submodules
  typedef struct packed {
    logic [7:0] lock;
    logic [7:0] oc_lo;
    logic [7:0] oc_hi;
    logic [7:0] rdata;
  } pbocr_state_s;

  pbocr_state_s            st_r;
  pbocr_state_s            st_nxt;
  pbocr_pkg::pbocr_wr_s    wr;
  pbocr_pkg::pbocr_phase_s ph [pbocr_pkg::BAL_PHASES];
  logic                    unlocked;

  assign wr.wr_en  = i_wr_en;
  assign wr.addr   = i_addr;
  assign wr.wdata  = i_wdata;
  // lock register itself is never gated, otherwise the lock could not be lifted
  assign unlocked  = (st_r.lock != pbocr_pkg::LOCK_VALUE);

  pbocr_phase_reg #(
    .GAIN_ADDR   (pbocr_pkg::ADDR_P6_GAIN),
    .OFFSET_ADDR (pbocr_pkg::ADDR_P6_OFFSET)
  ) u_ph6 (
    .i_sys_clk  (i_sys_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_wr       (wr),
    .i_unlocked (unlocked),
    .o_phase    (ph[0])
  );

  pbocr_phase_reg #(
    .GAIN_ADDR   (pbocr_pkg::ADDR_P7_GAIN),
    .OFFSET_ADDR (pbocr_pkg::ADDR_P7_OFFSET)
  ) u_ph7 (
    .i_sys_clk  (i_sys_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_wr       (wr),
    .i_unlocked (unlocked),
    .o_phase    (ph[1])
  );

  pbocr_phase_reg #(
    .GAIN_ADDR   (pbocr_pkg::ADDR_P8_GAIN),
    .OFFSET_ADDR (pbocr_pkg::ADDR_P8_OFFSET)
  ) u_ph8 (
    .i_sys_clk  (i_sys_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_wr       (wr),
    .i_unlocked (unlocked),
    .o_phase    (ph[2])
  );

  always_comb begin
    st_nxt = st_r;
    if (i_wr_en) begin
      if (i_addr == pbocr_pkg::ADDR_LOCK) begin
        st_nxt.lock = i_wdata;
      end
      if (unlocked && i_addr == pbocr_pkg::ADDR_OC_LO) begin
        st_nxt.oc_lo = i_wdata;
      end
      if (unlocked && i_addr == pbocr_pkg::ADDR_OC_HI) begin
        st_nxt.oc_hi = i_wdata;
      end
    end
    // read data registered; reads ignore the lock
    case (i_addr)
      pbocr_pkg::ADDR_LOCK:      st_nxt.rdata = st_r.lock;
      pbocr_pkg::ADDR_P6_GAIN:   st_nxt.rdata = {3'h0, ph[0].gain};
      pbocr_pkg::ADDR_P6_OFFSET: st_nxt.rdata = {3'h0, ph[0].offset};
      pbocr_pkg::ADDR_P7_GAIN:   st_nxt.rdata = {3'h0, ph[1].gain};
      pbocr_pkg::ADDR_P7_OFFSET: st_nxt.rdata = {3'h0, ph[1].offset};
      pbocr_pkg::ADDR_P8_GAIN:   st_nxt.rdata = {3'h0, ph[2].gain};
      pbocr_pkg::ADDR_P8_OFFSET: st_nxt.rdata = {3'h0, ph[2].offset};
      pbocr_pkg::ADDR_OC_LO:     st_nxt.rdata = st_r.oc_lo;
      pbocr_pkg::ADDR_OC_HI:     st_nxt.rdata = st_r.oc_hi;
      default:                   st_nxt.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r.lock  <= pbocr_pkg::LOCK_RESET;
      st_r.oc_lo <= pbocr_pkg::OC_RESET;
      st_r.oc_hi <= pbocr_pkg::OC_RESET;
      st_r.rdata <= 8'h00;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata   = st_r.rdata;
  assign o_locked  = !unlocked;
  // phase eight on top, each phase {gain, sign, magnitude}
  assign o_bal_cfg = {ph[2], ph[1], ph[0]};
  // phase n field at bits 2n-1:2n-2, phase one lowest
  assign o_oc_gain = {st_r.oc_hi, st_r.oc_lo};

  a_oc_locked_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_wr_en && !unlocked) |=> ($stable(st_r.oc_lo) && $stable(st_r.oc_hi)))
    else $error("overcurrent gain changed while locked");

  a_oc_lo_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_wr_en && unlocked && i_addr == pbocr_pkg::ADDR_OC_LO)
      |=> (o_oc_gain[7:0] == $past(i_wdata)))
    else $error("phases one to four gain not stored");

  a_oc_hi_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_wr_en && unlocked && i_addr == pbocr_pkg::ADDR_OC_HI)
      |=> (o_oc_gain[15:8] == $past(i_wdata)))
    else $error("phases five to eight gain not stored");

  a_lock_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_wr_en && i_addr == pbocr_pkg::ADDR_LOCK)
      |=> (o_locked == ($past(i_wdata) == pbocr_pkg::LOCK_VALUE)))
    else $error("lock flag does not follow register zero");

  a_read_gain6: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_addr == pbocr_pkg::ADDR_P6_GAIN) |=> (o_rdata == {3'h0, $past(ph[0].gain)}))
    else $error("phase six gain read wrong");

  a_lock_always_wr: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_wr_en && i_addr == pbocr_pkg::ADDR_LOCK)
      |=> (st_r.lock == $past(i_wdata)))
    else $error("lock register write not stored");

  a_ce_freeze: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!i_ce)
      |=> ($stable(st_r) && $stable(o_bal_cfg)))
    else $error("state moved while clock enable low");

  a_p7_gain_lands: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_wr_en && unlocked && i_addr == pbocr_pkg::ADDR_P7_GAIN)
      |=> (o_bal_cfg[19:15] == $past(i_wdata[4:0])))
    else $error("phase seven gain not stored");

  a_p8_ofs_lands: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_wr_en && unlocked && i_addr == pbocr_pkg::ADDR_P8_OFFSET)
      |=> (o_bal_cfg[24:20] == $past(i_wdata[4:0])))
    else $error("phase eight offset not stored");

  a_bal_locked_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_wr_en && !unlocked)
      |=> $stable(o_bal_cfg))
    else $error("balance settings changed while locked");

  a_read_lock: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_addr == pbocr_pkg::ADDR_LOCK)
      |=> (o_rdata == $past(st_r.lock)))
    else $error("lock register read wrong");

  a_read_oc_lo: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_addr == pbocr_pkg::ADDR_OC_LO)
      |=> (o_rdata == $past(st_r.oc_lo)))
    else $error("phases one to four gain read wrong");

  a_read_oc_hi: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_addr == pbocr_pkg::ADDR_OC_HI)
      |=> (o_rdata == $past(st_r.oc_hi)))
    else $error("phases five to eight gain read wrong");

  a_read_ofs6: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_addr == pbocr_pkg::ADDR_P6_OFFSET)
      |=> (o_rdata == {3'h0, $past(ph[0].offset)}))
    else $error("phase six offset read wrong");

  a_read_gain7: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_addr == pbocr_pkg::ADDR_P7_GAIN)
      |=> (o_rdata == {3'h0, $past(ph[1].gain)}))
    else $error("phase seven gain read wrong");

  a_read_ofs7: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_addr == pbocr_pkg::ADDR_P7_OFFSET)
      |=> (o_rdata == {3'h0, $past(ph[1].offset)}))
    else $error("phase seven offset read wrong");

  a_read_gain8: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_addr == pbocr_pkg::ADDR_P8_GAIN)
      |=> (o_rdata == {3'h0, $past(ph[2].gain)}))
    else $error("phase eight gain read wrong");

  a_read_ofs8: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_addr == pbocr_pkg::ADDR_P8_OFFSET)
      |=> (o_rdata == {3'h0, $past(ph[2].offset)}))
    else $error("phase eight offset read wrong");

  // holes read zero so a probing host never sees stale data
  a_unmapped_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && (i_addr > pbocr_pkg::ADDR_OC_HI ||
              (i_addr != pbocr_pkg::ADDR_LOCK && i_addr < pbocr_pkg::ADDR_P6_GAIN)))
      |=> (o_rdata == 8'h00))
    else $error("unmapped address read not zero");

  c_locked_write: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_wr_en && !unlocked && i_addr == pbocr_pkg::ADDR_OC_LO);
  c_unlock_again: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_locked ##1 !o_locked);
  c_offset_write: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_wr_en && unlocked && i_addr == pbocr_pkg::ADDR_P8_OFFSET);
  c_frozen_write: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_ce && i_wr_en);
  c_lock_reg_read: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && !i_wr_en && o_locked && i_addr == pbocr_pkg::ADDR_LOCK);

endmodule : pbocr_regs

// ### pbocr_host.sv
`timescale 1ns/10ps
module pbocr_host (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_rdata,
  output logic            o_ce,
  output logic            o_wr_en,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  initial begin
    o_ce    = 1'b1;
    o_wr_en = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end

  // strobe left high between writes so it never toggles twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    o_wr_en = 1'b1;
    o_addr  = a;
    o_wdata = d;
    @(posedge i_sys_clk);
    #1;
  endtask : wr

  // data lines flip while idle so stale values cannot pass as valid
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    o_wr_en = 1'b0;
    o_addr  = a;
    o_wdata = ~o_wdata;
    @(posedge i_sys_clk);
    #1;
    d = i_rdata;
  endtask : rd

  // enable moves with the other inputs, just after an edge
  task automatic set_ce(input logic v);
    o_ce = v;
  endtask : set_ce

  // clear the lock value before touching gated registers
  task automatic unlock;
    wr(pbocr_pkg::ADDR_LOCK, 8'h00);
  endtask : unlock
endmodule : pbocr_host

// ### pbocr_regs_tb.sv
`timescale 1ns/10ps
module pbocr_regs_tb;
  logic        i_sys_clk;
  logic        i_rst_n;
  logic        ce;
  logic        wr_en;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  rv;
  logic        locked;
  logic [15:0] oc;
  logic [29:0] bal;
  int          error_cnt;
  int          cmp_count;
  int          cyc;
  logic [7:0]  gv[3] = '{8'hFF, 8'h00, 8'h0F};
  logic [7:0]  ov[3] = '{8'h1F, 8'h10, 8'h05};

  always #20 i_sys_clk = ~i_sys_clk;

  pbocr_host HOST (.i_sys_clk(i_sys_clk), .i_rdata(rdata), .o_ce(ce), .o_wr_en(wr_en),
                   .o_addr(addr), .o_wdata(wdata));
  pbocr_regs DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_wr_en(wr_en),
                  .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_locked(locked),
                  .o_bal_cfg(bal), .o_oc_gain(oc));

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    HOST.rd(a, rv);
    chk(nm, {8'h00, rv}, {8'h00, e});
  endtask : rchk

  task automatic close_out;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // whole run needs well under a hundred cycles
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    i_sys_clk = 1'b0;
    i_rst_n   = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    cyc       = 0;
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_rst_n = 1'b1;
    chk("locked", {15'h0, locked}, 16'h0000);
    chk("oc_gain", oc, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      chk("bal reset", {6'h00, bal[10*i +: 10]}, 16'h0200);
    end
    for (int i = 0; i < 3; i++) begin
      rchk("gain reset", 8'h1B + 8'(2 * i), 8'h10);
      rchk("offset reset", 8'h1C + 8'(2 * i), 8'h00);
    end
    rchk("oc lo reset", 8'h21, 8'h00);
    rchk("oc hi reset", 8'h22, 8'h00);
    for (int i = 0; i < 3; i++) begin
      HOST.wr(8'h1B + 8'(2 * i), gv[i]);
      HOST.wr(8'h1C + 8'(2 * i), ov[i]);
    end
    for (int i = 0; i < 3; i++) begin
      rchk("gain", 8'h1B + 8'(2 * i), gv[i] & 8'h1F);
      rchk("offset", 8'h1C + 8'(2 * i), ov[i] & 8'h1F);
    end
    chk("bal ph6", {6'h00, bal[9:0]}, 16'h03FF);
    chk("bal ph7", {6'h00, bal[19:10]}, 16'h0010);
    chk("bal ph8", {6'h00, bal[29:20]}, 16'h01E5);
    HOST.wr(8'h21, 8'h1B);
    HOST.wr(8'h22, 8'hE4);
    chk("oc_gain", oc, 16'hE41B);
    rchk("oc hi", 8'h22, 8'hE4);
    rchk("unmapped", 8'h23, 8'h00);
    HOST.wr(pbocr_pkg::ADDR_LOCK, pbocr_pkg::LOCK_VALUE);
    chk("locked", {15'h0, locked}, 16'h0001);
    HOST.wr(8'h21, 8'h00);
    HOST.wr(8'h1B, 8'h03);
    HOST.wr(8'h20, 8'h00);
    chk("oc_gain locked", oc, 16'hE41B);
    rchk("gain locked", 8'h1B, 8'h1F);
    rchk("offset locked", 8'h20, 8'h05);
    chk("bal locked", {6'h00, bal[9:0]}, 16'h03FF);
    rchk("lock reg", 8'h00, 8'hA6);
    HOST.unlock();
    chk("locked", {15'h0, locked}, 16'h0000);
    HOST.wr(8'h21, 8'hAA);
    chk("oc_gain", oc, 16'hE4AA);
    HOST.wr(pbocr_pkg::ADDR_LOCK, 8'hA7);
    chk("locked", {15'h0, locked}, 16'h0000);
    HOST.wr(8'h22, 8'h1B);
    chk("oc_gain near key", oc, 16'h1BAA);
    HOST.set_ce(1'b0);
    HOST.wr(8'h21, 8'h55);
    chk("oc_gain frozen", oc, 16'h1BAA);
    HOST.set_ce(1'b1);
    HOST.wr(8'h21, 8'h55);
    chk("oc_gain", oc, 16'h1B55);
    i_rst_n = 1'b0;
    @(posedge i_sys_clk);
    #1;
    i_rst_n = 1'b1;
    chk("oc_gain reset", oc, 16'h0000);
    chk("locked reset", {15'h0, locked}, 16'h0000);
    rchk("gain reset", 8'h1B, 8'h10);
    close_out();
  end
endmodule : pbocr_regs_tb
